//--- rtl/i2cse_top.sv
// slave-only two-wire bus engine with register port
`timescale 1ns/1ns
`include "i2cse_defs.svh"
module i2cse_top (
   // clock, enable and reset
   input  wire logic        clk_sys_i,
   input  wire logic        ce_i,
   input  wire logic        arst_n_i,
   // register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output      logic [15:0] reg_rdata_o,
   // bus pins, open drain
   input  wire logic        scl_i,
   output      logic        scl_o,
   output      logic        scl_oe_o,
   input  wire logic        sda_i,
   output      logic        sda_o,
   output      logic        sda_oe_o,
   // interrupt request pulse
   output      logic        irq_o
);
   import i2cse_pkg::*;

   // ----------------------------------------------------------------------
   // reset release and pin conditioning
   // ----------------------------------------------------------------------
   logic [1:0] rst_s_q;
   logic       rst_n;

   // asynchronous assert, synchronous release
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s_q <= 2'h0;
      end else begin
         rst_s_q <= {rst_s_q[0], 1'b1};
      end
   end
   assign rst_n = rst_s_q[1];

   i2cse_sync_if sy ();

   i2cse_pin_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .ce_i      (ce_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .bus       (sy.src)
   );

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [6:0]   ctrl_q;
   logic [6:0]   own_addr_q;
   logic [7:0]   tx_data_q;
   logic [7:0]   receive_bits_q;
   logic         start_seen_flag_q;
   logic         addr_match_flag_q;
   logic         byte_done_flag_q;
   logic         stop_seen_flag_q;
   logic         restart_other_flag_q;
   logic         bit_mismatch_flag_q;
   logic         ack_sent_record_q;
   logic         busy_q;
   logic         addressed_flag_q;
   logic         rw_q;
   logic         restart_q;
   i2cse_state_t state_q;
   logic [7:0]   shift_q;
   logic [3:0]   bit_cnt_q;
   logic         sda_drv_q;
   logic         drv_off_q;
   logic         ack_sent_q;
   logic         ack_nak_q;
   logic         wait_pend_q;
   logic         addr_phase_q;

   logic start_irq_enable;
   logic stop_irq_enable;
   logic restart_other_irq_enable;
   logic stop_other_qualifier;
   logic ack_to_send;
   logic wr_ctrl;
   logic wr_clr;
   logic release_wait;
   logic addr_hit;
   logic ev_start;
   logic ev_addr;
   logic ev_done;
   logic ev_stop;
   logic ev_rsto;
   logic ev_err;

   assign start_irq_enable         = ctrl_q[`I2CSE_CTRL_STARTIE];
   assign stop_irq_enable          = ctrl_q[`I2CSE_CTRL_STOPIE];
   assign restart_other_irq_enable = ctrl_q[`I2CSE_CTRL_RSTIE];
   assign stop_other_qualifier     = ctrl_q[`I2CSE_CTRL_QUAL];
   assign ack_to_send              = ctrl_q[`I2CSE_CTRL_ACK];
   assign wr_ctrl                  = reg_wr_i && ce_i && reg_addr_i == `I2CSE_REG_CTRL;
   assign wr_clr                   = reg_wr_i && ce_i && reg_addr_i == `I2CSE_REG_CLEAR;
   // release bit is self-clearing: writing it frees the held clock
   assign release_wait             = wr_ctrl && reg_wdata_i[`I2CSE_CTRL_RELEASE];

   // software-written configuration, one word per register
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q     <= `I2CSE_CTRL_RST;
         own_addr_q <= `I2CSE_ADDR_RST;
         tx_data_q  <= 8'h00;
      end else if (ce_i && reg_wr_i) begin
         case (reg_addr_i)
            `I2CSE_REG_CTRL:   ctrl_q     <= {1'b0, reg_wdata_i[5:0]};
            `I2CSE_REG_ADDR:   own_addr_q <= reg_wdata_i[6:0];
            `I2CSE_REG_TXDATA: tx_data_q  <= reg_wdata_i[7:0];
            default:           ctrl_q     <= ctrl_q;
         endcase
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 16'h0000;
      end else if (ce_i) begin
         reg_rdata_o <= 16'h0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `I2CSE_REG_CTRL:   reg_rdata_o <= {9'h000, ctrl_q};
               `I2CSE_REG_ADDR:   reg_rdata_o <= {9'h000, own_addr_q};
               `I2CSE_REG_RXDATA: reg_rdata_o <= {8'h00, receive_bits_q};
               `I2CSE_REG_TXDATA: reg_rdata_o <= {8'h00, tx_data_q};
               `I2CSE_REG_STATUS: reg_rdata_o <= {5'h00, rw_q, state_q == I2CSE_WAIT, addressed_flag_q,
                                                  busy_q, ack_sent_record_q, bit_mismatch_flag_q,
                                                  restart_other_flag_q, stop_seen_flag_q,
                                                  byte_done_flag_q, addr_match_flag_q, start_seen_flag_q};
               default:           reg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // bus engine
   // ----------------------------------------------------------------------
   // the address is the first seven bits in; the read/write bit sits below it
   assign addr_hit = ctrl_q[`I2CSE_CTRL_EN] && shift_q[7:1] == own_addr_q;

   // shift, count and state sequencing; slave role only
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= I2CSE_IDLE;
         shift_q      <= 8'h00;
         bit_cnt_q    <= 4'h0;
         rw_q         <= 1'b0;
         ack_nak_q    <= 1'b1;
         wait_pend_q  <= 1'b0;
         addr_phase_q <= 1'b0;
      end else if (ce_i) begin
         if (sy.start_det) begin
            state_q      <= I2CSE_ADDR;
            bit_cnt_q    <= `I2CSE_BITS_BYTE;
            addr_phase_q <= 1'b1;
         end else if (sy.stop_det) begin
            state_q <= I2CSE_IDLE;
         end else begin
            case (state_q)
               I2CSE_ADDR, I2CSE_RX, I2CSE_TX: begin
                  if (sy.scl_rise) begin
                     shift_q   <= {shift_q[6:0], sy.sda};
                     bit_cnt_q <= bit_cnt_q - 4'h1;
                  end
                  if (sy.scl_fall && bit_cnt_q == 4'h0) begin
                     if (state_q == I2CSE_ADDR && !addr_hit) begin
                        state_q <= I2CSE_SKIP;
                     end else begin
                        state_q <= I2CSE_ACK;
                        if (state_q == I2CSE_ADDR) begin
                           rw_q <= shift_q[0];
                        end
                     end
                  end
               end
               I2CSE_ACK: begin
                  if (sy.scl_rise) begin
                     ack_nak_q <= sy.sda;
                  end
                  if (sy.scl_fall) begin
                     state_q      <= I2CSE_WAIT;
                     wait_pend_q  <= 1'b1;
                     addr_phase_q <= 1'b0;
                  end
               end
               I2CSE_WAIT: begin
                  wait_pend_q <= 1'b0;
                  if (release_wait) begin
                     bit_cnt_q <= `I2CSE_BITS_BYTE;
                     state_q   <= rw_q ? (ack_nak_q ? I2CSE_SKIP : I2CSE_TX) : I2CSE_RX;
                     shift_q   <= tx_data_q;
                  end
               end
               I2CSE_SKIP: begin
                  state_q <= I2CSE_SKIP;
               end
               default: begin
                  state_q <= I2CSE_IDLE;
               end
            endcase
         end
      end
   end

   // data line drive: ack bit on receive, tx bits on transmit
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_drv_q  <= 1'b0;
         drv_off_q  <= 1'b0;
         ack_sent_q <= 1'b1;
      end else if (ce_i) begin
         if (sy.start_det || sy.stop_det) begin
            sda_drv_q <= 1'b0;
            drv_off_q <= 1'b0;
         end else begin
            if (state_q == I2CSE_TX && sy.scl_rise && sda_drv_q != ~sy.sda && !drv_off_q) begin
               drv_off_q <= 1'b1;
            end else if (drv_off_q && state_q == I2CSE_WAIT && wait_pend_q) begin
               drv_off_q <= 1'b0; // following byte done, driver may return
            end
            if (sy.scl_fall) begin
               if (bit_cnt_q == 4'h0 && (state_q == I2CSE_RX || (state_q == I2CSE_ADDR && addr_hit))) begin
                  sda_drv_q  <= ~ack_to_send;
                  ack_sent_q <= ack_to_send;
               end else if (state_q == I2CSE_TX && bit_cnt_q != 4'h0) begin
                  sda_drv_q <= ~shift_q[7];
               end else begin
                  sda_drv_q <= 1'b0;
               end
            end
            // a released read pushes its first bit out now: no falling edge comes before the master's rise
            if (state_q == I2CSE_WAIT && release_wait) begin
               sda_drv_q <= rw_q && !ack_nak_q && !tx_data_q[7];
            end
         end
      end
   end

   // hold the clock low in the wait state; bit pushed out on release
   assign scl_o    = 1'b0;
   assign scl_oe_o = state_q == I2CSE_WAIT;
   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_drv_q && !drv_off_q;

   // events toward the flags
   assign ev_start = sy.start_det;
   assign ev_addr  = state_q == I2CSE_ACK && sy.scl_fall && addr_phase_q;
   assign ev_done  = state_q == I2CSE_ACK && sy.scl_fall && !addr_phase_q;
   assign ev_stop  = sy.stop_det && stop_irq_enable && !(addressed_flag_q && stop_other_qualifier);
   assign ev_rsto  = restart_q && addressed_flag_q && state_q == I2CSE_ADDR && sy.scl_fall
                     && bit_cnt_q == 4'h0 && !addr_hit && restart_other_irq_enable;
   assign ev_err   = state_q == I2CSE_TX && sy.scl_rise && sda_drv_q == sy.sda && !drv_off_q;

   // sticky flags; a set in the same cycle as a clear wins
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         start_seen_flag_q    <= 1'b0;
         addr_match_flag_q    <= 1'b0;
         byte_done_flag_q     <= 1'b0;
         stop_seen_flag_q     <= 1'b0;
         restart_other_flag_q <= 1'b0;
         bit_mismatch_flag_q  <= 1'b0;
      end else if (ce_i) begin
         if (wr_clr) begin
            start_seen_flag_q    <= start_seen_flag_q    & ~reg_wdata_i[`I2CSE_ST_START];
            addr_match_flag_q    <= addr_match_flag_q    & ~reg_wdata_i[`I2CSE_ST_ADDR];
            byte_done_flag_q     <= byte_done_flag_q     & ~reg_wdata_i[`I2CSE_ST_DONE];
            stop_seen_flag_q     <= stop_seen_flag_q     & ~reg_wdata_i[`I2CSE_ST_STOP];
            restart_other_flag_q <= restart_other_flag_q & ~reg_wdata_i[`I2CSE_ST_RSTO];
            bit_mismatch_flag_q  <= bit_mismatch_flag_q  & ~reg_wdata_i[`I2CSE_ST_ERR];
         end
         if (ev_start) begin
            start_seen_flag_q <= 1'b1;
         end
         if (ev_addr) begin
            addr_match_flag_q <= 1'b1;
         end
         if (ev_done) begin
            byte_done_flag_q <= 1'b1;
         end
         if (ev_stop) begin
            stop_seen_flag_q <= 1'b1;
            if (addressed_flag_q) begin
               addr_match_flag_q <= 1'b1;
            end
         end
         if (ev_rsto) begin
            restart_other_flag_q <= 1'b1;
         end
         if (ev_err) begin
            bit_mismatch_flag_q <= 1'b1;
         end
      end
   end

   // bus state, selection and captured data
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_q            <= 1'b0;
         addressed_flag_q  <= 1'b0;
         restart_q         <= 1'b0;
         receive_bits_q    <= 8'h00;
         ack_sent_record_q <= 1'b0;
      end else if (ce_i) begin
         if (sy.start_det) begin
            busy_q    <= 1'b1;
            restart_q <= busy_q;
         end else if (sy.stop_det) begin
            busy_q           <= 1'b0;
            restart_q        <= 1'b0;
            addressed_flag_q <= 1'b0;
         end else if (state_q == I2CSE_ADDR && sy.scl_fall && bit_cnt_q == 4'h0) begin
            addressed_flag_q <= addr_hit;
         end
         if (state_q == I2CSE_ACK && sy.scl_fall) begin
            ack_sent_record_q <= ack_sent_q;
            if (!addr_phase_q && !rw_q) begin
               receive_bits_q <= shift_q;
            end
         end
      end
   end

   // one-cycle interrupt pulse on entry to the wait state or bus events
   assign irq_o = (ev_start && start_irq_enable)
                  || ev_addr || ev_done
                  || ev_stop || ev_rsto;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_ack_end;
      state_q == I2CSE_ACK && sy.scl_fall;
   endsequence

   chk_start_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ce_i && sy.start_det |=> start_seen_flag_q)
      else $error("start flag not set");
   chk_start_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      sy.start_det && !start_irq_enable && state_q != I2CSE_ACK && !sy.stop_det |-> !irq_o || ev_rsto)
      else $error("start irq not gated");
   chk_wait_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      s_ack_end ##0 (ce_i && !sy.start_det && !sy.stop_det) |=> state_q == I2CSE_WAIT && scl_oe_o)
      else $error("wait state not entered");
   chk_busy_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ce_i && sy.stop_det && !sy.start_det |=> !busy_q)
      else $error("busy not cleared");
   chk_ack_record: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      s_ack_end ##0 ce_i |=> ack_sent_record_q == $past(ack_sent_q))
      else $error("ack record wrong");
   chk_rx_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      s_ack_end ##0 (ce_i && !addr_phase_q && !rw_q) |=> receive_bits_q == $past(shift_q))
      else $error("receive data not captured");
   chk_mismatch_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ce_i && ev_err |=> bit_mismatch_flag_q && drv_off_q)
      else $error("mismatch not flagged");
   chk_driver_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      drv_off_q && state_q != I2CSE_WAIT && !sy.start_det && !sy.stop_det |-> !sda_oe_o ##1 drv_off_q)
      else $error("driver active after mismatch");
   chk_done_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ce_i && ev_done |-> irq_o ##1 byte_done_flag_q)
      else $error("byte done not flagged");
endmodule

//--- rtl/i2cse_defs.svh
// constants of the two-wire slave engine
`ifndef I2CSE_DEFS_SVH
`define I2CSE_DEFS_SVH
// register indices on the plain register port
`define I2CSE_REG_CTRL    4'h0
`define I2CSE_REG_ADDR    4'h1
`define I2CSE_REG_STATUS  4'h2
`define I2CSE_REG_RXDATA  4'h3
`define I2CSE_REG_TXDATA  4'h4
`define I2CSE_REG_CLEAR   4'h5
// control register bit positions
`define I2CSE_CTRL_EN       0
`define I2CSE_CTRL_ACK      1
`define I2CSE_CTRL_QUAL     2
`define I2CSE_CTRL_RSTIE    3
`define I2CSE_CTRL_STOPIE   4
`define I2CSE_CTRL_STARTIE  5
`define I2CSE_CTRL_RELEASE  6
// status register bit positions
`define I2CSE_ST_START   0
`define I2CSE_ST_ADDR    1
`define I2CSE_ST_DONE    2
`define I2CSE_ST_STOP    3
`define I2CSE_ST_RSTO    4
`define I2CSE_ST_ERR     5
`define I2CSE_ST_ACKREC  6
`define I2CSE_ST_BUSY    7
`define I2CSE_ST_SEL     8
`define I2CSE_ST_WAIT    9
`define I2CSE_ST_RW      10
// reset values and the bit count loaded for each byte
`define I2CSE_CTRL_RST   7'h00
`define I2CSE_ADDR_RST   7'h00
`define I2CSE_BITS_BYTE  4'h8
`endif

//--- rtl/i2cse_pkg.sv
// types of the two-wire slave engine
package i2cse_pkg;
   typedef enum logic [2:0] {
      I2CSE_IDLE  = 3'b000,
      I2CSE_ADDR  = 3'b001,
      I2CSE_RX    = 3'b010,
      I2CSE_TX    = 3'b011,
      I2CSE_ACK   = 3'b100,
      I2CSE_WAIT  = 3'b101,
      I2CSE_SKIP  = 3'b110
   } i2cse_state_t;
endpackage

//--- rtl/i2cse_sync_if.sv
// bundle between the pin synchroniser and the engine
`timescale 1ns/1ns
interface i2cse_sync_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
   modport dst (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

//--- rtl/i2cse_pin_sync.sv
// two-flop pin synchroniser with edge, start and stop detection
`timescale 1ns/1ns
module i2cse_pin_sync (
   // clock and reset
   input  wire logic  clk_sys_i,
   input  wire logic  rst_n_i,
   input  wire logic  ce_i,
   // raw pins
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   // conditioned bus
   i2cse_sync_if.src  bus
);
   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic       scl_q;
   logic       sda_q;

   // only the second flop and the held copy feed detection
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else if (ce_i) begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end

   // start is sda falling while scl high, stop is sda rising while scl high
   assign bus.scl       = scl_q;
   assign bus.sda       = sda_q;
   assign bus.scl_rise  = ce_i & scl_s_q[1] & ~scl_q;
   assign bus.scl_fall  = ce_i & ~scl_s_q[1] & scl_q;
   assign bus.start_det = ce_i & scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   assign bus.stop_det  = ce_i & scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
endmodule

//--- verif/i2cse_master_model.sv
// bus master model driving the two-wire pins through open-drain pull-downs
`timescale 1ns/1ns
module i2cse_master_model (
   // clock
   input  wire logic clk_sys_i,
   // resolved bus lines, pulled up when nobody pulls low
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-down enables
   output logic      scl_low_o,
   output logic      sda_low_o
);
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   // three cycles; with the edge wait beside it each half of the 320 ns link clock is four
   task automatic hf();
      repeat (3) @(posedge clk_sys_i);
   endtask
   // let the clock rise; a slave may hold it low, so wait for it (the bench watchdog bounds a hang)
   task automatic rise();
      scl_low_o <= 1'b0;
      @(posedge clk_sys_i);
      while (scl_i !== 1'b1) begin
         @(posedge clk_sys_i);
      end
      hf();
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      sda_low_o <= 1'b0;
      hf();
      rise();
      sda_low_o <= 1'b1;
      hf();
      scl_low_o <= 1'b1;
      hf();
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      @(posedge clk_sys_i);
      sda_low_o <= 1'b1;
      hf();
      rise();
      sda_low_o <= 1'b0;
      hf();
   endtask
   // one bit; data changes one cycle after the clock fell to keep clear of start/stop
   task automatic bit_x(input logic d, output logic s);
      @(posedge clk_sys_i);
      sda_low_o <= ~d;
      hf();
      rise();
      s = sda_i;
      scl_low_o <= 1'b1;
   endtask
   // eight bits msb first, then the acknowledge slot driven with mack
   task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] got, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
         got[i] = s;
      end
      bit_x(mack, ack);
      sda_low_o <= 1'b0;
      // let the slave see the last falling edge before software looks at it
      hf();
   endtask
endmodule

//--- verif/i2c_slave_engine_bench.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ns
`include "i2cse_defs.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module i2c_slave_engine_bench;
   logic        clk_sys_i = 1'b0;
   logic        ce_i, arst_n_i, reg_wr_i, reg_rd_i, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl, m_sda, ak;
   logic [3:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, st;
   logic [7:0]  got;
   int          miscompares = 0, checks_done = 0, irqs = 0, n;
   // open-drain lines with pull-ups
   wire         scl_w = ~(scl_oe_o | m_scl);
   wire         sda_w = ~(sda_oe_o | m_sda);
   always #20 clk_sys_i = ~clk_sys_i;
   // count interrupt pulses
   always @(posedge clk_sys_i) if (irq_o === 1'b1) irqs <= irqs + 1;
   i2cse_top i2cse_top_i (.clk_sys_i(clk_sys_i), .ce_i(ce_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .irq_o(irq_o));
   i2cse_master_model i2cse_master_model_i (.clk_sys_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w),
      .scl_low_o(m_scl), .sda_low_o(m_sda));
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_sys_i);
      d = reg_rdata_o;
      @(posedge clk_sys_i);
   endtask
   task automatic sb(input int b, input logic e, input string nm);
      rd(`I2CSE_REG_STATUS, st);
      `CHK(nm, e, st[b])
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog, well above the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      miscompares++;
      wrap_up();
   end
   initial begin
      {ce_i, arst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      ce_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd(`I2CSE_REG_STATUS, st);
      `CHK("status reset", 16'h0000, st)
      rd(4'hF, st);
      `CHK("unmapped read", 16'h0000, st)
      // own address, enable with all interrupt enables, acknowledge low
      wr(`I2CSE_REG_ADDR, 16'h002A);
      wr(`I2CSE_REG_CTRL, 16'h0039);
      n = irqs;
      i2cse_master_model_i.start();
      sb(`I2CSE_ST_START, 1'b1, "start flag");
      sb(`I2CSE_ST_BUSY, 1'b1, "busy");
      `CHK("start irq", n + 1, irqs)
      i2cse_master_model_i.xfer(8'h54, 1'b1, got, ak);
      `CHK("addr ack", 1'b0, ak)
      sb(`I2CSE_ST_ADDR, 1'b1, "addr flag");
      `CHK("clock held", 1'b1, scl_oe_o)
      sb(`I2CSE_ST_WAIT, 1'b1, "wait state");
      wr(`I2CSE_REG_CLEAR, 16'h003F);
      wr(`I2CSE_REG_CTRL, 16'h0079);
      i2cse_master_model_i.xfer(8'hA5, 1'b1, got, ak);
      `CHK("data ack", 1'b0, ak)
      rd(`I2CSE_REG_RXDATA, st);
      `CHK("rx byte", 16'h00A5, st)
      sb(`I2CSE_ST_DONE, 1'b1, "rx done");
      sb(`I2CSE_ST_ACKREC, 1'b0, "ack record");
      // acknowledge level 1: the slave leaves data high
      wr(`I2CSE_REG_CTRL, 16'h007B);
      i2cse_master_model_i.xfer(8'h3C, 1'b1, got, ak);
      `CHK("nack", 1'b1, ak)
      sb(`I2CSE_ST_ACKREC, 1'b1, "nack record");
      rd(`I2CSE_REG_RXDATA, st);
      `CHK("rx byte 2", 16'h003C, st)
      // repeated start toward another slave
      wr(`I2CSE_REG_CTRL, 16'h0079);
      i2cse_master_model_i.start();
      i2cse_master_model_i.xfer(8'h22, 1'b1, got, ak);
      `CHK("other addr", 1'b1, ak)
      sb(`I2CSE_ST_RSTO, 1'b1, "restart other");
      n = irqs;
      i2cse_master_model_i.stop();
      sb(`I2CSE_ST_BUSY, 1'b0, "busy stop");
      sb(`I2CSE_ST_STOP, 1'b1, "stop flag");
      `CHK("stop irq", n + 1, irqs)
      // interrupt enables off: start recorded silently
      wr(`I2CSE_REG_CLEAR, 16'h003F);
      wr(`I2CSE_REG_CTRL, 16'h0001);
      wr(`I2CSE_REG_TXDATA, 16'h0080);
      n = irqs;
      i2cse_master_model_i.start();
      sb(`I2CSE_ST_START, 1'b1, "start gated");
      `CHK("no start irq", n, irqs)
      // read: master pulls bit 7 low against a sent 1, rest must be released
      i2cse_master_model_i.xfer(8'h55, 1'b1, got, ak);
      `CHK("read addr ack", 1'b0, ak)
      wr(`I2CSE_REG_CLEAR, 16'h003F);
      wr(`I2CSE_REG_CTRL, 16'h0041);
      i2cse_master_model_i.xfer(8'h7F, 1'b1, got, ak);
      `CHK("tx bits", 8'h7F, got)
      sb(`I2CSE_ST_ERR, 1'b1, "mismatch");
      sb(`I2CSE_ST_DONE, 1'b1, "tx done");
      wr(`I2CSE_REG_CTRL, 16'h0041);
      i2cse_master_model_i.stop();
      sb(`I2CSE_ST_STOP, 1'b0, "stop gated");
      sb(`I2CSE_ST_BUSY, 1'b0, "busy end");
      // stop while addressed: qualifier 0 flags it, qualifier 1 keeps it quiet
      for (int q = 0; q < 2; q++) begin
         i2cse_master_model_i.start();
         i2cse_master_model_i.xfer(8'h54, 1'b1, got, ak);
         wr(`I2CSE_REG_CLEAR, 16'h003F);
         wr(`I2CSE_REG_CTRL, q ? 16'h0055 : 16'h0051);
         i2cse_master_model_i.stop();
         sb(`I2CSE_ST_STOP, q == 0, "stop other");
         sb(`I2CSE_ST_ADDR, q == 0, "stop other addr");
      end
      // clock frozen only while the bus is idle: a write then is lost
      ce_i <= 1'b0;
      wr(`I2CSE_REG_ADDR, 16'h0055);
      ce_i <= 1'b1;
      rd(`I2CSE_REG_ADDR, st);
      `CHK("frozen write", 16'h002A, st)
      wrap_up();
   end
endmodule
